/* verilog/smm_cmd_handler.sv */
// target-side mode-sense and move-medium command handler, AHB-Lite slave
// assumes a front end loads the command block and pulls phase bytes via XFER
// Operation
// - both pages report page-savable bit set
// - baud page code 20h, length 02h
// - baud bytes MSB first, default 9600
// - parity page code 00h, length 02h
// - parity bit set means checking disabled
// - mode-select parity beats option switch
// - invalid fields give check condition, sense
// - data-in sends exactly the requested count
// - status byte, command complete, bus free
// - DBD and page code sense pointers
// - busy for other initiator or abort
// - reservation conflict if reserved elsewhere
// - check on parity with messages disabled, LUN, attention, reserved
// - move opcode A5h, three 16-bit addresses
// - transport field must match gripper address
// - pick to gripper, place from gripper
// - drive destination closes drive door
// - same address picks and replaces, empty errors
// - drive-to-drive locked until door reopened
// - gripper to gripper rejected, no motion
// - invert flag set is invalid parameter
// - element reserved elsewhere: conflict, sense cleared
`timescale 1ns/10ps
`include "smm_regs.svh"
module smm_cmd_handler #(
   parameter logic [15:0] TPORT_RST = 16'h0000,
   parameter logic [15:0] DRIVE_ADDR = 16'h0001,
   parameter logic [15:0] SLOT_FIRST = 16'h0002,
   parameter logic [15:0] SLOT_LAST = 16'h000B
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // motion requests, parity control and command phase
   output logic o_pick,
   output logic o_place,
   output logic o_door_close,
   output logic o_par_chk_dis,
   output smm_pkg::smm_phase_t o_phase
);
   import smm_pkg::*;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [31:0] cdb_ff [3]; // command block, byte n at word n/4 lane n%4
   logic [2:0] id_ff; // initiator of the current command
   logic [11:0] env_ff; // library and bus conditions
   logic [15:0] baud_ff; // serial rate
   logic [15:0] tport_ff; // gripper address set through the config register
   logic msel_vld_ff; // parity written by mode select
   logic msel_par_ff; // its value, 1 = checking disabled
   smm_phase_t phase_ff; // command phase
   logic [7:0] stat_ff; // status byte of the last command
   smm_sense_t sense_ff; // held sense data
   logic sense_vld_ff; // sense present
   logic [2:0] owner_ff; // initiator owning the sense
   logic lock_ff; // drive-to-drive lockout
   logic door_d_ff; // door state one cycle back
   logic [7:0] idx_ff; // data-in byte counter
   logic wr_ff; // write data phase pending
   logic [7:0] waddr_ff; // its address

   // ----------------------------------------
   // field decode
   // ----------------------------------------
   function automatic logic [7:0] cb(input int n);
      cb = cdb_ff[n / 4][(n % 4) * 8 +: 8];
   endfunction

   // classify an element address against the configured map
   function automatic smm_elem_t cls(input logic [15:0] a);
      if (a == tport_ff) cls = SMM_EL_MT;
      else if (a == DRIVE_ADDR) cls = SMM_EL_DT;
      else if (a >= SLOT_FIRST && a <= SLOT_LAST) cls = SMM_EL_ST;
      else cls = SMM_EL_BAD;
   endfunction

   function automatic smm_sense_t mk(input logic [3:0] k, input logic [7:0] c,
         input logic [7:0] q, input logic [2:0] f, input logic [2:0] bp,
         input logic [15:0] fp);
      mk = '{k, c, q, f[2], f[1], f[0], bp, fp};
   endfunction

   // environment bits
   wire door_open = env_ff[0];
   wire grip_full = env_ff[1];
   wire src_full = env_ff[2];
   wire dst_full = env_ff[3];
   wire resv_other = env_ff[4];
   wire elem_resv = env_ff[5];
   wire busy_other = env_ff[6];
   wire aborting = env_ff[7];
   wire par_err = env_ff[8];
   wire msg_en = env_ff[9];
   wire unit_atn = env_ff[10];
   wire par_opt = env_ff[11];
   wire [7:0] opc = cb(0);
   // whole bytes first: a function result cannot be bit-selected
   wire [7:0] cb1 = cb(1);
   wire [7:0] cb2 = cb(2);
   wire [7:0] cb10 = cb(10);
   wire [2:0] lun = cb1[7:5];
   wire dbd = cb1[3];
   wire [5:0] pgc = cb2[5:0];
   wire [7:0] alloc = cb(4);
   wire [15:0] tpt_a = {cb(2), cb(3)};
   wire [15:0] src_a = {cb(4), cb(5)};
   wire [15:0] dst_a = {cb(6), cb(7)};
   wire smm_elem_t sc = cls(src_a);
   wire smm_elem_t dc = cls(dst_a);
   wire ms_rsv = cb1[4] | (|cb1[2:0]) | (|cb2[7:6]);
   wire mv_rsv = (|cb1[4:0]) | (|cb(8)) | (|cb(9)) | (|cb10[7:1]) | (|cb(11));
   wire pg_ok = (pgc == `SMM_PG_BAUD) || (pgc == `SMM_PG_PAR);
   wire is_dtd = (sc == SMM_EL_DT) && (dc == SMM_EL_DT);
   // mode select overrides the option switch
   wire par_dis = msel_vld_ff ? msel_par_ff : par_opt;

   // ----------------------------------------
   // command evaluation, priority ordered
   // ----------------------------------------
   logic [7:0] ev_st; // resulting status
   smm_sense_t ev_sn; // resulting sense
   logic ev_clr; // sense to be cleared
   logic ev_data; // enter data-in
   logic ev_mv; // motion granted
   always_comb begin
      ev_st = `SMM_ST_CHECK;
      ev_sn = '0;
      ev_clr = 1'b0;
      ev_data = 1'b0;
      ev_mv = 1'b0;
      if (busy_other || aborting) ev_st = `SMM_ST_BUSY;
      else if (resv_other) ev_st = `SMM_ST_RESV;
      else if (par_err && !msg_en) ev_sn = mk(4'hB, 8'h47, 8'h00, 3'h0, 3'h0, 16'h0000);
      else if (lun != 3'h0) ev_sn = mk(4'h5, 8'h25, 8'h00, 3'h0, 3'h0, 16'h0000);
      else if (unit_atn) ev_sn = mk(4'h6, 8'h29, 8'h00, 3'h0, 3'h0, 16'h0000);
      else if (opc == `SMM_OP_MSENSE) begin
         if (ms_rsv) ev_sn = mk(4'h5, 8'h24, 8'h00, 3'h0, 3'h0, 16'h0000);
         else if (dbd) ev_sn = mk(4'h5, 8'h24, 8'h00, 3'h7, 3'h3, 16'h0001);
         else if (!pg_ok) ev_sn = mk(4'h5, 8'h24, 8'h00, 3'h7, 3'h5, 16'h0002);
         else begin
            ev_st = `SMM_ST_GOOD;
            ev_data = (alloc != 8'h00);
         end
      end else if (opc == `SMM_OP_MOVE) begin
         if (mv_rsv) ev_sn = mk(4'h5, 8'h24, 8'h00, 3'h0, 3'h0, 16'h0000);
         else if (cb10[0]) ev_sn = mk(4'h5, 8'h24, 8'h00, 3'h7, 3'h0, 16'h000A);
         else if (tpt_a != tport_ff) ev_sn = mk(4'h5, 8'h24, 8'h80, 3'h6, 3'h0, 16'h0002);
         else if (sc == SMM_EL_BAD) ev_sn = mk(4'h5, 8'h24, 8'h80, 3'h6, 3'h0, 16'h0004);
         else if (dc == SMM_EL_BAD) ev_sn = mk(4'h5, 8'h24, 8'h80, 3'h6, 3'h0, 16'h0006);
         else if (elem_resv) begin
            ev_st = `SMM_ST_RESV;
            ev_clr = 1'b1;
         end
         else if (sc == SMM_EL_MT && dc == SMM_EL_MT)
            ev_sn = mk(4'h5, 8'h24, 8'h80, 3'h6, 3'h0, 16'h0006);
         else if (is_dtd && lock_ff) ev_sn = mk(4'h5, 8'h3B, 8'h84, 3'h0, 3'h0, 16'h0000);
         else if (sc == SMM_EL_DT && !door_open)
            ev_sn = mk(4'h5, 8'h3B, 8'h83, 3'h0, 3'h0, 16'h0000);
         else if (dc == SMM_EL_DT && !door_open)
            ev_sn = mk(4'h5, 8'h3B, 8'h84, 3'h0, 3'h0, 16'h0000);
         else if (grip_full && sc != SMM_EL_MT)
            ev_sn = mk(4'h5, 8'h3B, 8'h80, 3'h0, 3'h0, 16'h0000);
         else if (!grip_full && sc == SMM_EL_MT)
            ev_sn = mk(4'h5, 8'h3B, 8'h0E, 3'h0, 3'h0, 16'h0000);
         // empty source, also for same address
         else if (sc != SMM_EL_MT && !src_full)
            ev_sn = mk(4'h5, 8'h3B, 8'h0E, 3'h0, 3'h0, 16'h0000);
         else if (dc != SMM_EL_MT && src_a != dst_a && dst_full)
            ev_sn = mk(4'h5, 8'h3B, 8'h0D, 3'h0, 3'h0, 16'h0000);
         else begin
            ev_st = `SMM_ST_GOOD;
            ev_mv = 1'b1;
         end
      end else ev_sn = mk(4'h5, 8'h20, 8'h00, 3'h0, 3'h0, 16'h0000);
   end

   // ----------------------------------------
   // mode page bytes
   // ----------------------------------------
   logic [7:0] pg_byte; // page byte at idx_ff
   always_comb begin
      pg_byte = 8'h00;
      if (pgc == `SMM_PG_BAUD) begin
         case (idx_ff)
            8'h00: pg_byte = `SMM_PG_SAVE | {2'b00, `SMM_PG_BAUD};
            8'h01: pg_byte = `SMM_PG_LEN;
            8'h02: pg_byte = baud_ff[15:8];
            8'h03: pg_byte = baud_ff[7:0];
            default: pg_byte = 8'h00;
         endcase
      end else begin
         case (idx_ff)
            8'h00: pg_byte = `SMM_PG_SAVE | {2'b00, `SMM_PG_PAR};
            8'h01: pg_byte = `SMM_PG_LEN;
            8'h02: pg_byte = 8'(par_dis) << `SMM_PAR_BIT;
            default: pg_byte = 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire acc = i_hsel & i_htrans[1] & i_hready;
   wire [7:0] ra = i_haddr[7:0];
   wire rd_acc = acc & ~i_hwrite;
   wire pop = rd_acc && (ra == `SMM_XFER);
   wire fetch = rd_acc && (ra == `SMM_SENSE1);
   wire go = wr_ff && (waddr_ff == `SMM_CTRL) && i_hwdata[0] && (phase_ff == SMM_FREE);
   wire last = (idx_ff == alloc - 8'h01);
   logic [31:0] rmux; // read data for the accepted address
   always_comb begin
      if (ra == `SMM_CDB0) rmux = cdb_ff[0];
      else if (ra == `SMM_CDB1) rmux = cdb_ff[1];
      else if (ra == `SMM_CDB2) rmux = cdb_ff[2];
      else if (ra == `SMM_CTRL) rmux = {28'h0, id_ff, 1'b0};
      else if (ra == `SMM_ENV) rmux = {20'h0, env_ff};
      else if (ra == `SMM_CFG) rmux = {tport_ff, baud_ff};
      else if (ra == `SMM_MSEL) rmux = {29'h0, par_dis, msel_par_ff, msel_vld_ff};
      else if (ra == `SMM_STAT) rmux = {15'h0, lock_ff, stat_ff, 5'h0, phase_ff};
      else if (ra == `SMM_SENSE0) rmux = {sense_vld_ff, 3'h0, sense_ff.key, sense_ff.asc,
         sense_ff.ascq, 5'h0, owner_ff};
      else if (ra == `SMM_SENSE1) rmux = {9'h0, sense_ff.sksv, sense_ff.cd, sense_ff.bpv,
         1'b0, sense_ff.bptr, sense_ff.fptr};
      // phase bytes pulled one read at a time
      else if (ra == `SMM_XFER) begin
         if (phase_ff == SMM_DATA) rmux = {24'h0, pg_byte};
         else if (phase_ff == SMM_STAT) rmux = {24'h0, stat_ff};
         else if (phase_ff == SMM_MSG) rmux = {24'h0, `SMM_MSG_DONE};
         else rmux = 32'h0;
      end else rmux = 32'h0;
   end

   // ----------------------------------------
   // bus slave flops, zero wait states
   // ----------------------------------------
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_hrdata <= 32'h0;
         o_hreadyout <= 1'b0;
         o_hresp <= 1'b0;
         wr_ff <= 1'b0;
         waddr_ff <= 8'h00;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         wr_ff <= acc & i_hwrite;
         waddr_ff <= ra;
         // read data registered in the address phase
         if (rd_acc) o_hrdata <= rmux;
      end
   end

   // software-written registers, updated in the write data phase
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cdb_ff <= '{default: 32'h0};
         id_ff <= 3'h0;
         env_ff <= 12'h000;
         baud_ff <= `SMM_BAUD_RST;
         tport_ff <= TPORT_RST;
         msel_vld_ff <= 1'b0;
         msel_par_ff <= 1'b0;
      end else if (wr_ff) begin
         if (waddr_ff == `SMM_CDB0 && phase_ff == SMM_FREE) cdb_ff[0] <= i_hwdata;
         if (waddr_ff == `SMM_CDB1 && phase_ff == SMM_FREE) cdb_ff[1] <= i_hwdata;
         if (waddr_ff == `SMM_CDB2 && phase_ff == SMM_FREE) cdb_ff[2] <= i_hwdata;
         if (go) id_ff <= i_hwdata[3:1];
         if (waddr_ff == `SMM_ENV) env_ff <= i_hwdata[11:0];
         if (waddr_ff == `SMM_CFG) {tport_ff, baud_ff} <= i_hwdata;
         if (waddr_ff == `SMM_MSEL) {msel_par_ff, msel_vld_ff} <= i_hwdata[1:0];
      end
   end

   // ----------------------------------------
   // phase sequencer
   // ----------------------------------------
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         phase_ff <= SMM_FREE;
         idx_ff <= 8'h00;
         stat_ff <= `SMM_ST_GOOD;
      end else begin
         case (phase_ff)
            SMM_FREE: if (go) phase_ff <= SMM_EVAL;
            // check first, then data or status
            SMM_EVAL: begin
               stat_ff <= ev_st;
               idx_ff <= 8'h00;
               phase_ff <= ev_data ? SMM_DATA : SMM_STAT;
            end
            SMM_DATA: if (pop) begin
               idx_ff <= idx_ff + 8'h01;
               if (last) phase_ff <= SMM_STAT;
            end
            SMM_STAT: if (pop) phase_ff <= SMM_MSG;
            SMM_MSG: if (pop) phase_ff <= SMM_FREE;
            default: phase_ff <= SMM_FREE;
         endcase
      end
   end

   // ----------------------------------------
   // sense, lockout and motion
   // ----------------------------------------
   wire ev_now = (phase_ff == SMM_EVAL);
   wire door_rise = door_open & ~door_d_ff; // door has just been reopened
   wire ev_chk = ev_now && (ev_st == `SMM_ST_CHECK);
   // a new command from the owner replaces its sense
   wire replace = ev_now && (ev_clr || (sense_vld_ff && owner_ff == id_ff));
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sense_ff <= '0;
         sense_vld_ff <= 1'b0;
         owner_ff <= 3'h0;
      end else if (ev_chk) begin
         // load wins over a fetch in the same cycle
         sense_ff <= ev_sn;
         sense_vld_ff <= 1'b1;
         owner_ff <= id_ff;
      end else if (replace || fetch) begin
         // cleared on element-reserved conflict, replace or fetch
         sense_ff <= '0;
         sense_vld_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lock_ff <= 1'b0;
         door_d_ff <= 1'b0;
         o_pick <= 1'b0;
         o_place <= 1'b0;
         o_door_close <= 1'b0;
         o_par_chk_dis <= 1'b0;
         o_phase <= SMM_FREE;
      end else begin
         // set by a granted drive-to-drive move, set wins
         door_d_ff <= door_open;
         if (ev_now && ev_mv && is_dtd) lock_ff <= 1'b1;
         // only a fresh opening clears: the granted move itself needs the door open
         else if (door_rise) lock_ff <= 1'b0;
         // pick from a source, place into a destination
         o_pick <= ev_now && ev_mv && (sc != SMM_EL_MT);
         o_place <= ev_now && ev_mv && (dc != SMM_EL_MT);
         o_door_close <= ev_now && ev_mv && (dc == SMM_EL_DT);
         o_par_chk_dis <= par_dis;
         o_phase <= phase_ff;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb_m @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   wire pop_d = (phase_ff == SMM_DATA) && pop;
   sequence s_stat_pop;
      (phase_ff == SMM_STAT) && pop;
   endsequence
   sequence s_msg_pop;
      (phase_ff == SMM_MSG) && pop;
   endsequence
   property p_pg_head;
      pop_d && idx_ff == 8'h00 && pgc == `SMM_PG_BAUD |=> o_hrdata == 32'h0000_00A0;
   endproperty
   a_pg_head: assert property (p_pg_head) else $error("baud page header wrong");
   property p_baud_msb;
      pop_d && idx_ff == 8'h02 && pgc == `SMM_PG_BAUD |=> o_hrdata[7:0] == $past(baud_ff[15:8]);
   endproperty
   a_baud_msb: assert property (p_baud_msb) else $error("baud msb not first");
   property p_par_bit;
      pop_d && idx_ff == 8'h02 && pgc == `SMM_PG_PAR |=> o_hrdata[5] == $past(par_dis);
   endproperty
   a_par_bit: assert property (p_par_bit) else $error("parity bit wrong");
   property p_msel;
      msel_vld_ff |=> o_par_chk_dis == $past(msel_par_ff);
   endproperty
   a_msel: assert property (p_msel) else $error("mode select did not win");
   property p_chk;
      ev_chk |=> phase_ff == SMM_STAT && sense_vld_ff && stat_ff == `SMM_ST_CHECK;
   endproperty
   a_chk: assert property (p_chk) else $error("check not reported");
   property p_data_end;
      pop_d && last |=> phase_ff == SMM_STAT;
   endproperty
   a_data_end: assert property (p_data_end) else $error("data count wrong");
   property p_close;
      s_stat_pop |=> phase_ff == SMM_MSG;
   endproperty
   a_close: assert property (p_close) else $error("no command complete");
   property p_free;
      s_msg_pop |=> phase_ff == SMM_FREE;
   endproperty
   a_free: assert property (p_free) else $error("no bus free");
   property p_dbd;
      ev_now && opc == `SMM_OP_MSENSE && ev_st == `SMM_ST_CHECK && dbd && !ms_rsv
         && lun == 3'h0 && !unit_atn && !(par_err && !msg_en)
         |=> sense_ff.bptr == 3'h3 && sense_ff.fptr == 16'h0001;
   endproperty
   a_dbd: assert property (p_dbd) else $error("dbd pointers wrong");
   property p_busy;
      ev_now && busy_other |=> stat_ff == `SMM_ST_BUSY;
   endproperty
   a_busy: assert property (p_busy) else $error("busy not returned");
   property p_mtmt;
      ev_now && ev_st != `SMM_ST_RESV && opc == `SMM_OP_MOVE && sc == SMM_EL_MT
         && dc == SMM_EL_MT |=> !o_pick && !o_place && stat_ff != `SMM_ST_GOOD;
   endproperty
   a_mtmt: assert property (p_mtmt) else $error("gripper move accepted");
   property p_lock;
      lock_ff && !door_open && ev_now && opc == `SMM_OP_MOVE && is_dtd |=> !o_door_close;
   endproperty
   a_lock: assert property (p_lock) else $error("locked drive move ran");
endmodule // smm_cmd_handler

/* include/smm_regs.svh */
// register map, codes and reset values of the mode/move command handler
// assumes a 32-bit AHB-Lite slave with one word per register
`ifndef SMM_REGS_SVH
`define SMM_REGS_SVH
// ----------------------------------------
// byte offsets
// ----------------------------------------
`define SMM_CDB0 8'h00
`define SMM_CDB1 8'h04
`define SMM_CDB2 8'h08
`define SMM_CTRL 8'h0C
`define SMM_ENV 8'h10
`define SMM_CFG 8'h14
`define SMM_MSEL 8'h18
`define SMM_STAT 8'h1C
`define SMM_SENSE0 8'h20
`define SMM_SENSE1 8'h24
`define SMM_XFER 8'h28
// ----------------------------------------
// reset values and page layout
// ----------------------------------------
`define SMM_BAUD_RST 16'h2580
`define SMM_PG_BAUD 6'h20
`define SMM_PG_PAR 6'h00
`define SMM_PG_LEN 8'h02
`define SMM_PG_SAVE 8'h80
`define SMM_PG_BYTES 8'h04
`define SMM_PAR_BIT 5
// ----------------------------------------
// opcodes, status and message bytes
// ----------------------------------------
`define SMM_OP_MSENSE 8'h1A
`define SMM_OP_MOVE 8'hA5
`define SMM_ST_GOOD 8'h00
`define SMM_ST_CHECK 8'h02
`define SMM_ST_BUSY 8'h08
`define SMM_ST_RESV 8'h18
`define SMM_MSG_DONE 8'h00
`endif

/* include/smm_pkg.sv */
// types shared by the mode/move command handler
// assumes nothing beyond the register header
package smm_pkg;
   // bus phase of the command in progress
   typedef enum logic [2:0] {SMM_FREE, SMM_EVAL, SMM_DATA, SMM_STAT, SMM_MSG} smm_phase_t;
   // kind of element behind an address
   typedef enum logic [1:0] {SMM_EL_MT, SMM_EL_DT, SMM_EL_ST, SMM_EL_BAD} smm_elem_t;
   // sense data as held for the failing initiator
   typedef struct packed {
      logic [3:0] key;
      logic [7:0] asc;
      logic [7:0] ascq;
      logic sksv;
      logic cd;
      logic bpv;
      logic [2:0] bptr;
      logic [15:0] fptr;
   } smm_sense_t;
endpackage

/* bench/smm_init_model.sv */
// initiator side model: an ahb-lite master that loads commands and pops bytes
// assumes a single zero-wait slave whose hreadyout is fed back as hready
`timescale 1ns/10ps
module smm_init_model (
   // clock and bus answer
   input wire logic i_mclk,
   input wire logic i_hready,
   input wire logic [31:0] i_hrdata,
   // bus request
   output logic o_hsel,
   output logic [31:0] o_haddr,
   output logic [1:0] o_htrans,
   output logic o_hwrite,
   output logic [2:0] o_hsize,
   output logic [31:0] o_hwdata
);
   // ----------------------------------------
   // idle bus at time zero
   // ----------------------------------------
   initial begin
      o_hsel = 1'b0;
      o_haddr = 32'h0;
      o_htrans = 2'h0;
      o_hwrite = 1'b0;
      o_hsize = 3'h2;
      o_hwdata = 32'hFFFF_FFFF;
   end
   // one single word transfer; address held until hready, then data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge i_mclk);
      o_hsel <= 1'b1;
      o_htrans <= 2'h2;
      o_haddr <= {24'h0, a};
      o_hwrite <= w;
      @(posedge i_mclk iff i_hready);
      o_htrans <= 2'h0;
      o_hwdata <= d;
      @(posedge i_mclk iff i_hready);
      q = i_hrdata;
      // released data lines must not keep looking valid
      o_hwdata <= ~d;
   endtask
endmodule // smm_init_model

/* bench/tb_smm_cmd_handler.sv */
// testbench of the mode/move command handler: pages, status, sense, moves
// assumes the handler answers the register bus with zero wait states
`timescale 1ns/10ps
`include "smm_regs.svh"
module tb_smm_cmd_handler;
   import smm_pkg::*;
   logic mclk, arst_n, hsel, hwrite, rdy, pick, place, door, pdis, hresp;
   logic [2:0] ini; // initiator id that run starts commands for
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   smm_phase_t ph;
   int fails, n_tests, n_pick, n_place, n_door;
   smm_cmd_handler i_smm_cmd_handler (.i_mclk(mclk), .i_arst_n(arst_n), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata), .o_hreadyout(rdy),
      .o_hresp(hresp), .o_pick(pick), .o_place(place), .o_door_close(door),
      .o_par_chk_dis(pdis), .o_phase(ph));
   smm_init_model i_smm_init_model (.i_mclk(mclk), .i_hready(rdy), .i_hrdata(hrdata),
      .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
      .o_hsize(hsize), .o_hwdata(hwdata));
   // ----------------------------------------
   // clock, pulse counters, helpers
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // motion pulses counted per move
   always @(posedge mclk) begin
      if (pick === 1'b1) n_pick <= n_pick + 1;
      if (place === 1'b1) n_place <= n_place + 1;
      if (door === 1'b1) n_door <= n_door + 1;
   end
   task automatic test_done();
      if (fails == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_smm_init_model.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a);
      i_smm_init_model.xfer(1'b0, a, 32'h0, q);
   endtask
   // load a block, start it for initiator ini, poll until data or status
   task automatic run(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2,
         input logic [31:0] env);
      n_pick = 0;
      n_place = 0;
      n_door = 0;
      wr(`SMM_CDB0, w0);
      wr(`SMM_CDB1, w1);
      wr(`SMM_CDB2, w2);
      wr(`SMM_ENV, env);
      wr(`SMM_CTRL, {28'h0, ini, 1'b1});
      q = 32'h0;
      for (int i = 0; i < 20 && q[2:0] != SMM_DATA && q[2:0] != SMM_STAT; i++) begin
         rd(`SMM_STAT);
      end
   endtask
   // pop one phase byte
   task automatic xb(input logic [7:0] e);
      rd(`SMM_XFER);
      chk({24'h0, q[7:0]}, {24'h0, e});
   endtask
   // status byte, command complete, then bus free
   task automatic tail(input logic [7:0] st);
      xb(st);
      xb(`SMM_MSG_DONE);
      rd(`SMM_STAT);
      chk({29'h0, q[2:0]}, {29'h0, SMM_FREE});
      chk({29'h0, ph}, {29'h0, SMM_FREE});
   endtask
   // move block: addresses most significant byte first, invert in byte ten
   task automatic mv(input logic [15:0] t, input logic [15:0] s, input logic [15:0] d,
         input logic inv, input logic [31:0] env, input logic [7:0] st, input int pk,
         input int pl, input int dr);
      run({t[7:0], t[15:8], 8'h00, `SMM_OP_MOVE}, {d[7:0], d[15:8], s[7:0], s[15:8]},
         {8'h0, 7'h0, inv, 16'h0}, env);
      tail(st);
      chk(n_pick, pk);
      chk(n_place, pl);
      chk(n_door, dr);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // baud page at default rate, asked for six bytes
   task automatic t_baud();
      run(32'h0020_001A, 32'h0000_0006, 32'h0, 32'h0);
      xb(8'hA0);
      xb(8'h02);
      xb(8'h25);
      xb(8'h80);
      xb(8'h00);
      xb(8'h00);
      tail(`SMM_ST_GOOD);
   endtask
   // parity page: mode select value wins over the option switch
   task automatic t_par();
      wr(`SMM_MSEL, 32'h3);
      run(32'h0000_001A, 32'h4, 32'h0, 32'h0);
      chk({31'h0, pdis}, 32'h1);
      xb(8'h80);
      xb(8'h02);
      xb(8'h20);
      xb(8'h00);
      tail(`SMM_ST_GOOD);
      wr(`SMM_MSEL, 32'h1);
      run(32'h0000_001A, 32'h3, 32'h0, 32'h800);
      chk({31'h0, pdis}, 32'h0);
      xb(8'h80);
      xb(8'h02);
      xb(8'h00);
      tail(`SMM_ST_GOOD);
      wr(`SMM_MSEL, 32'h0);
      wr(`SMM_ENV, 32'h800);
      rd(`SMM_STAT);
      chk({31'h0, pdis}, 32'h1);
   endtask
   // bad dbd then bad page: no data phase, pointers, fetch clears
   task automatic t_sense();
      run(32'h0020_081A, 32'h4, 32'h0, 32'h0);
      chk({29'h0, q[2:0]}, {29'h0, SMM_STAT});
      chk({29'h0, ph}, {29'h0, SMM_STAT});
      tail(`SMM_ST_CHECK);
      rd(`SMM_SENSE0);
      chk(q, 32'h8524_0001);
      rd(`SMM_SENSE1);
      chk(q, 32'h0073_0001);
      rd(`SMM_SENSE0);
      chk({31'h0, q[31]}, 32'h0);
      run(32'h0015_001A, 32'h4, 32'h0, 32'h0);
      tail(`SMM_ST_CHECK);
      rd(`SMM_SENSE0);
      chk(q, 32'h8524_0001);
      rd(`SMM_SENSE1);
      chk(q, 32'h0075_0002);
   endtask
   // busy, abort, reserved unit, parity, attention, lun, reserved bit
   task automatic t_stat();
      logic [11:0] env [7] = '{12'h040, 12'h080, 12'h010, 12'h100, 12'h400, 12'h0, 12'h0};
      logic [7:0] b1 [7] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h20, 8'h10};
      logic [7:0] st [7] = '{8'h08, 8'h08, 8'h18, 8'h02, 8'h02, 8'h02, 8'h02};
      for (int i = 0; i < 7; i++) begin
         run({16'h0020, b1[i], 8'h1A}, 32'h4, 32'h0, {20'h0, env[i]});
         tail(st[i]);
      end
   endtask
   // pick, place, gripper to gripper, same slot, drive lock, bad fields
   task automatic t_move();
      mv(16'h0, 16'h2, 16'h0, 1'b0, 32'h4, `SMM_ST_GOOD, 1, 0, 0);
      mv(16'h0, 16'h0, 16'h1, 1'b0, 32'h3, `SMM_ST_GOOD, 0, 1, 1);
      mv(16'h0, 16'h0, 16'h0, 1'b0, 32'h2, `SMM_ST_CHECK, 0, 0, 0);
      mv(16'h0, 16'h3, 16'h3, 1'b0, 32'h4, `SMM_ST_GOOD, 1, 1, 0);
      run(32'h0000_00A5, 32'h0300_0300, 32'h0, 32'h0);
      tail(`SMM_ST_CHECK);
      rd(`SMM_SENSE0);
      chk(q, 32'h853B_0E01);
      mv(16'h0, 16'h1, 16'h1, 1'b0, 32'h5, `SMM_ST_GOOD, 1, 1, 1);
      rd(`SMM_STAT);
      chk({31'h0, q[16]}, 32'h1);
      mv(16'h0, 16'h1, 16'h1, 1'b0, 32'h4, `SMM_ST_CHECK, 0, 0, 0);
      rd(`SMM_SENSE0);
      chk(q, 32'h853B_8401);
      wr(`SMM_ENV, 32'h1);
      rd(`SMM_STAT);
      chk({31'h0, q[16]}, 32'h0);
      mv(16'h5, 16'h2, 16'h0, 1'b0, 32'h4, `SMM_ST_CHECK, 0, 0, 0);
      mv(16'h0, 16'h2, 16'h0, 1'b1, 32'h4, `SMM_ST_CHECK, 0, 0, 0);
      ini = 3'h2;
      mv(16'h0, 16'h2, 16'h0, 1'b0, 32'h24, `SMM_ST_RESV, 0, 0, 0);
      ini = 3'h1;
      rd(`SMM_SENSE0);
      chk({31'h0, q[31]}, 32'h0);
   endtask
   // watchdog well beyond the expected run length
   initial begin
      #400000;
      fails++;
      test_done();
   end
   initial begin
      arst_n = 1'b0;
      fails = 0;
      n_tests = 0;
      ini = 3'h1;
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      rd(`SMM_CFG);
      chk(q, 32'h0000_2580);
      chk({31'h0, hresp}, 32'h0);
      t_baud();
      t_par();
      t_sense();
      t_stat();
      t_move();
      test_done();
   end
endmodule // tb_smm_cmd_handler
